// [verif/tb.sv]
// Self-checking bench for the translate-and-test step datapath
`timescale 1ns/1ps
module tb;
    import tti_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic seg = 1'b0;
    logic step_abort = 1'b0;
    logic [ADDR_W-1:0] sp = 32'h0;
    logic [ADDR_W-1:0] tbp = 32'h0;
    logic [CNT_W-1:0] cnt = 16'h0;
    logic [1:0] lat = 2'h0;
    logic mem_rd_req, mem_rd_valid, step_busy, step_done;
    logic zero_flag, overflow_flag;
    logic [ADDR_W-1:0] mem_addr, ptr_out;
    logic [BYTE_W-1:0] mem_rd_data, res_byte;
    logic [CNT_W-1:0] cnt_out;
    int mismatches = 0;
    int compares = 0;
    int seed = 32'hF252;

    tti_step i_dut (.sys_clk(sys_clk), .reset(reset),
        .translate_test_step_op(start), .segmented_mode(seg),
        .step_abort(step_abort), .string_pointer(sp),
        .table_base_pointer(tbp), .counter_in(cnt),
        .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
        .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
        .step_busy(step_busy), .step_done(step_done),
        .string_pointer_out(ptr_out), .counter_out(cnt_out),
        .table_result_byte_reg(res_byte), .zero_flag(zero_flag),
        .overflow_flag(overflow_flag));

    tti_mem_model i_mem (.sys_clk(sys_clk), .reset(reset),
        .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
        .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .lat(lat));

    // 250 MHz clock
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // Same store contents as the memory model, worked out independently
    function automatic logic [7:0] mem_val(input logic [31:0] a);
        return (a[3:0] == 4'h0) ? 8'h00 :
            a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24];
    endfunction

    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----
    // One step; ab 1 cancels it in the string read, 2 in the table read
    // ----
    task automatic step(input logic [31:0] s, t, input logic [15:0] c,
                        input logic sm, input logic [1:0] ab);
        logic [31:0] sa, ta, rec0, rec1, old_p;
        logic [15:0] old_c;
        logic [7:0] res;
        int n, k;
        logic [31:0] exp_p;
        logic [7:0] old_r;
        logic old_z, old_v;
        sa = sm ? s : {16'h0000, s[15:0]};
        ta = {sm ? t[31:16] : 16'h0000, t[15:0] + {8'h00, mem_val(sa)}};
        res = mem_val(ta);
        old_p = ptr_out;
        old_c = cnt_out;
        old_r = res_byte;
        old_z = zero_flag;
        old_v = overflow_flag;
        // Offset wraps at 16 bits, segment field carried as is when segmented, zero otherwise
        exp_p = {sa[31:16], s[15:0] + 16'h1};
        n = 0;
        rec0 = 32'h0;
        rec1 = 32'h0;
        @(posedge sys_clk);
        sp <= s;
        tbp <= t;
        cnt <= c;
        seg <= sm;
        start <= 1'b1;
        lat <= 2'($random(seed));
        @(posedge sys_clk);
        start <= 1'b0;
        step_abort <= (ab == 2'h1);
        for (k = 0; k < 60; k++) begin
            @(negedge sys_clk);
            if (step_done === 1'b1 || (ab != 2'h0 && k == 8))
                break;
            if (mem_rd_req === 1'b1 && mem_rd_valid === 1'b1) begin
                if (n == 0)
                    rec0 = mem_addr;
                else
                    rec1 = mem_addr;
                n++;
                // Late cancel lands once the design sits in the table read
                if (ab == 2'h2 && n == 1) begin
                    @(posedge sys_clk);
                    step_abort <= 1'b1;
                end
            end
        end
        if (ab != 2'h0) begin
            check("done after abort", {31'h0, step_done}, 32'h0);
            check("busy after abort", {31'h0, step_busy}, 32'h0);
            check("pointer after abort", ptr_out, old_p);
            check("counter after abort", cnt_out, old_c);
            check("result after abort", res_byte, old_r);
            check("zero after abort", zero_flag, old_z);
            check("overflow after abort", overflow_flag, old_v);
            @(posedge sys_clk);
            step_abort <= 1'b0;
        end else begin
            check("string address", rec0, sa);
            check("table address", rec1, ta);
            check("read count", 32'(n), 32'h2);
            check("result byte", res_byte, res);
            check("zero flag", zero_flag, res == 8'h00);
            check("pointer", ptr_out, exp_p);
            check("counter", cnt_out, 16'(c - 16'h1));
            check("overflow", overflow_flag, c == 16'h1);
        end
    endtask

    // Main sequence: corner cases, then seeded random steps back to back
    initial begin
        int i;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        step(32'h1234FFFF, 32'h0077FFF0, 16'h0001, 1'b1, 2'h0);
        step(32'h0000FFFF, 32'hABCD0100, 16'h0000, 1'b0, 2'h0);
        step(32'h00AA2001, {16'h0055, 16'h1000 - 16'h008B}, 16'hFFFF,
             1'b1, 2'h0);
        step(32'h00000010, 32'h00000000, 16'h8000, 1'b0, 2'h1);
        step(32'h00000011, 32'h00000020, 16'h8000, 1'b0, 2'h2);
        step(32'h00000010, 32'h00000000, 16'h8000, 1'b0, 2'h0);
        $display("test corner done");
        // operands are separate values held by the bench
        for (i = 0; i < 200; i++) begin
            step($random(seed), $random(seed), 16'($random(seed)),
                 1'($random(seed)), (i % 10 == 9) ? 2'(i / 10 % 2 + 1) : 2'h0);
        end
        $display("test random done");
        final_report();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        final_report();
    end
endmodule

// [verif/tti_mem_model.sv]
// Behavioural memory holding the string and the translation table
`timescale 1ns/1ps
module tti_mem_model
    import tti_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Read port
    input wire logic mem_rd_req,
    input wire logic [ADDR_W-1:0] mem_addr,
    output logic mem_rd_valid,
    output logic [BYTE_W-1:0] mem_rd_data,
    // Wait states before each answer
    input wire logic [1:0] lat
);
    logic [1:0] wait_r;

    // full index range
    // Every address answers, so any index up to 8'hFF finds an entry
    function automatic logic [7:0] content(input logic [31:0] a);
        return (a[3:0] == 4'h0) ? 8'h00 :
            a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24];
    endfunction

    // One valid pulse per request; idle data toggles so a stale byte
    // can never pass for a fresh answer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mem_rd_valid <= 1'b0;
            mem_rd_data <= 8'h5A;
            wait_r <= 2'h0;
        end else if (!mem_rd_req || mem_rd_valid) begin
            mem_rd_valid <= 1'b0;
            mem_rd_data <= ~mem_rd_data;
            wait_r <= 2'h0;
        end else if (wait_r >= lat) begin
            mem_rd_valid <= 1'b1;
            mem_rd_data <= content(mem_addr);
        end else begin
            wait_r <= wait_r + 2'h1;
            mem_rd_data <= ~mem_rd_data;
        end
    end
endmodule

// [verilog/tti_offset_add.sv]
// Offset adder: zero-extended byte added to an address offset
`timescale 1ns/1ps
module tti_offset_add
    import tti_pkg::*;
#(
    parameter int W = OFF_W
) (
    // Operands
    input wire logic [W-1:0] offset,
    input wire logic [BYTE_W-1:0] addend,
    // Result
    output logic [W-1:0] sum
);
    // Unsigned extension with high-order zeros; carry out of the offset
    // is dropped so the segment field never changes
    wire logic [W-1:0] addend_ext;
    assign addend_ext = {{(W-BYTE_W){1'b0}}, addend};
    assign sum = offset + addend_ext;
endmodule

// [verilog/tti_pkg.sv]
// Shared widths and constants for the translate-and-test step datapath
package tti_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int OFF_W = 16;
    localparam int SEG_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = SEG_W + OFF_W;
    localparam int CNT_W = 16;
    // ----------------------------------------------------------------
    // Constant values
    // ----------------------------------------------------------------
    localparam logic [BYTE_W-1:0] PTR_STEP = 8'h01;
    localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [SEG_W-1:0] SEG_NONE = 16'h0000;
    // ----------------------------------------------------------------
    // Step sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TTI_IDLE,
        TTI_RD_STR,
        TTI_RD_TAB
    } tti_state_type;
endpackage

// [verilog/tti_step.sv]
// Translate-and-test step: string byte lookup, flag and pointer update
// Function
// - Read byte at string pointer address and use it as table index.
// - Table address is table base plus zero-extended index byte.
// - Fetch table byte and load it into the result byte register.
// - Zero flag set when loaded result byte is zero, else cleared.
// - Never write string byte or table entry; reads only.
// - After table byte load, increment string pointer by one.
// - Decrement the word counter by one as last update.
// - Table base register is left unchanged by the step.
// - Table spans up to 256 entries; shorter only if safe.
// - Overflow-position flag set when decremented counter is zero.
// - Pointers are word registers nonsegmented, register pairs segmented.
`timescale 1ns/1ps
module tti_step
    import tti_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Step control
    input wire logic translate_test_step_op,
    input wire logic segmented_mode,
    input wire logic step_abort,
    // Register operands
    input wire logic [ADDR_W-1:0] string_pointer,
    input wire logic [ADDR_W-1:0] table_base_pointer,
    input wire logic [CNT_W-1:0] counter_in,
    // Memory read port
    output logic mem_rd_req,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_rd_valid,
    input wire logic [BYTE_W-1:0] mem_rd_data,
    // Results
    output logic step_busy,
    output logic step_done,
    output logic [ADDR_W-1:0] string_pointer_out,
    output logic [CNT_W-1:0] counter_out,
    output logic [BYTE_W-1:0] table_result_byte_reg,
    output logic zero_flag,
    output logic overflow_flag
);
    // ----------------------------------------------------------------
    // State and captured operands
    // ----------------------------------------------------------------
    tti_state_type state_r, state_nxt;
    logic [ADDR_W-1:0] str_cap_r;
    logic [ADDR_W-1:0] base_cap_r;
    logic [CNT_W-1:0] cnt_cap_r;
    logic seg_cap_r;
    logic [BYTE_W-1:0] index_r;
    logic mem_rd_req_r;
    logic [ADDR_W-1:0] mem_addr_r;
    logic step_done_r;
    logic [ADDR_W-1:0] str_out_r;
    logic [CNT_W-1:0] cnt_out_r;
    logic [BYTE_W-1:0] result_r;
    logic zero_flag_r;
    logic ovf_flag_r;

    // ----------------------------------------------------------------
    // Address arithmetic
    // ----------------------------------------------------------------
    wire logic [OFF_W-1:0] tab_off;
    wire logic [OFF_W-1:0] str_inc_off;
    wire logic [SEG_W-1:0] str_seg_start;
    wire logic [SEG_W-1:0] str_seg_cap;
    wire logic [SEG_W-1:0] base_seg_cap;
    wire logic [ADDR_W-1:0] str_addr_start;
    wire logic [ADDR_W-1:0] tab_addr;
    wire logic [ADDR_W-1:0] str_next;
    wire logic [CNT_W-1:0] cnt_dec;
    wire logic take_step;
    wire logic rd_done;
    wire logic finish;
    wire logic abort_now;

    // full byte index
    // The whole 8-bit index reaches the adder, so 256 entries are addressable
    // base plus index
    tti_offset_add #(.W(OFF_W)) u_tab_add (
        .offset(base_cap_r[OFF_W-1:0]),
        .addend(mem_rd_data),
        .sum(tab_off)
    );

    tti_offset_add #(.W(OFF_W)) u_str_inc (
        .offset(str_cap_r[OFF_W-1:0]),
        .addend(PTR_STEP),
        .sum(str_inc_off)
    );

    // segment field only in segmented operation
    assign str_seg_start = segmented_mode ?
        string_pointer[ADDR_W-1:OFF_W] : SEG_NONE;
    assign str_seg_cap = seg_cap_r ? str_cap_r[ADDR_W-1:OFF_W] : SEG_NONE;
    assign base_seg_cap = seg_cap_r ? base_cap_r[ADDR_W-1:OFF_W] : SEG_NONE;
    assign str_addr_start = {str_seg_start, string_pointer[OFF_W-1:0]};
    assign tab_addr = {base_seg_cap, tab_off};
    assign str_next = {str_seg_cap, str_inc_off};
    assign cnt_dec = cnt_cap_r - CNT_STEP;

    // Sequencing conditions
    assign take_step = (state_r == TTI_IDLE) && translate_test_step_op;
    assign abort_now = (state_r != TTI_IDLE) && step_abort;
    assign rd_done = mem_rd_req_r && mem_rd_valid && !step_abort;
    assign finish = (state_r == TTI_RD_TAB) && rd_done;

    // ----------------------------------------------------------------
    // Next-state selection
    // ----------------------------------------------------------------
    // Abort wins over a read that lands in the same cycle
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            TTI_IDLE: begin
                if (translate_test_step_op) begin
                    state_nxt = TTI_RD_STR;
                end
            end
            TTI_RD_STR: begin
                if (step_abort) begin
                    state_nxt = TTI_IDLE;
                end else if (rd_done) begin
                    state_nxt = TTI_RD_TAB;
                end
            end
            TTI_RD_TAB: begin
                if (step_abort || rd_done) begin
                    state_nxt = TTI_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer and memory request
    // ----------------------------------------------------------------
    // read-only request path, there is no write strobe at all
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= TTI_IDLE;
            mem_rd_req_r <= 1'b0;
            mem_addr_r <= '0;
        end else begin
            state_r <= state_nxt;
            mem_rd_req_r <= (state_nxt != TTI_IDLE);
            if (take_step) begin
                mem_addr_r <= str_addr_start;
            end else if (state_r == TTI_RD_STR && rd_done) begin
                mem_addr_r <= tab_addr;
            end
        end
    end

    // operands captured once; the table base is never written back
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            str_cap_r <= '0;
            base_cap_r <= '0;
            cnt_cap_r <= '0;
            seg_cap_r <= 1'b0;
            index_r <= '0;
        end else if (take_step) begin
            str_cap_r <= string_pointer;
            base_cap_r <= table_base_pointer;
            cnt_cap_r <= counter_in;
            seg_cap_r <= segmented_mode;
        end else if (state_r == TTI_RD_STR && rd_done) begin
            index_r <= mem_rd_data;
        end
    end

    // ----------------------------------------------------------------
    // Architectural results
    // ----------------------------------------------------------------
    // results move only when the table read has completed
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            step_done_r <= 1'b0;
            str_out_r <= '0;
            cnt_out_r <= '0;
            result_r <= '0;
            zero_flag_r <= 1'b0;
            ovf_flag_r <= 1'b0;
        end else begin
            step_done_r <= finish;
            if (finish) begin
                result_r <= mem_rd_data;
                zero_flag_r <= (mem_rd_data == ZERO_BYTE);
                str_out_r <= str_next;
                cnt_out_r <= cnt_dec;
                ovf_flag_r <= (cnt_dec == CNT_ZERO);
            end
        end
    end

    // Outputs straight from flip-flops
    assign mem_rd_req = mem_rd_req_r;
    assign mem_addr = mem_addr_r;
    assign step_busy = mem_rd_req_r;
    assign step_done = step_done_r;
    assign string_pointer_out = str_out_r;
    assign counter_out = cnt_out_r;
    assign table_result_byte_reg = result_r;
    assign zero_flag = zero_flag_r;
    assign overflow_flag = ovf_flag_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_string_addr: assert property (
        $rose(mem_rd_req_r) |-> mem_addr_r[OFF_W-1:0] == str_cap_r[OFF_W-1:0])
        else $error("string read address wrong");
    a_table_addr: assert property (
        (state_r == TTI_RD_TAB) |-> mem_addr_r[OFF_W-1:0] ==
        OFF_W'(base_cap_r[OFF_W-1:0] + {ZERO_BYTE, index_r}))
        else $error("table address wrong");
    a_result_load: assert property (
        finish |=> step_done_r && result_r == $past(mem_rd_data))
        else $error("result byte not loaded");
    a_zero_flag: assert property (
        step_done_r |-> zero_flag_r == (result_r == ZERO_BYTE))
        else $error("zero flag mismatch");
    a_ptr_incr: assert property (
        step_done_r |-> str_out_r[OFF_W-1:0] ==
        OFF_W'(str_cap_r[OFF_W-1:0] + PTR_STEP))
        else $error("pointer not incremented");
    a_cnt_decr: assert property (
        step_done_r |-> cnt_out_r == CNT_W'(cnt_cap_r - CNT_STEP))
        else $error("counter not decremented");
    a_base_kept: assert property (
        (state_r != TTI_IDLE) |=> $stable(base_cap_r))
        else $error("table base changed");
    a_ovf_flag: assert property (
        step_done_r |-> ovf_flag_r == (cnt_out_r == CNT_ZERO))
        else $error("overflow flag mismatch");
    a_seg_kept: assert property (
        step_done_r && seg_cap_r |-> str_out_r[ADDR_W-1:OFF_W] ==
        str_cap_r[ADDR_W-1:OFF_W])
        else $error("segment field changed");
    a_abort_clean: assert property (
        abort_now |=> (state_r == TTI_IDLE) && !step_done_r &&
        $stable(cnt_out_r) && $stable(zero_flag_r))
        else $error("abort updated results");

    c_step_done: cover property (take_step ##[2:20] step_done_r);
    c_zero_hit: cover property (step_done_r && zero_flag_r);
    c_count_end: cover property (step_done_r && ovf_flag_r);
    c_abort_tab: cover property ((state_r == TTI_RD_TAB) && step_abort);
endmodule
